/* idt_chan_ctrl.sv */
/*
  Primary channel configuration and strobe timing: register bank on a
  classic Wishbone slave, access sequencing toward the drives, read-DMA
  flush request and slave fast-DMA mode tracking. Assumes access requests,
  set-features notices and the DMA interrupt are synchronous to ref_clk.
*/
`timescale 1ns/100ps

module idt_chan_ctrl #(
  parameter int ADR_W = 10,
  parameter logic [3:0] PART_ID = 4'h5 // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic acc_req,
  input wire logic acc_slave,
  input wire logic acc_nondata,
  input wire logic acc_write,
  input wire logic feat_udma_set,
  input wire logic feat_udma_clr,
  input wire logic dma_irq,
  output logic primary_read_strobe_n,
  output logic primary_write_strobe_n,
  output logic udma_write_strobe,
  output logic addr_valid,
  output logic acc_done,
  output logic chan_enable,
  output logic flush_read_dma,
  output logic [7:0] irq_route
);
  // register index is the word address, so ten address bits are needed
  if (ADR_W < 10) begin : g_bad_adr_w
    $error("ADR_W must be at least 10");
  end

  logic [7:0] int_line_q;
  logic [1:0] ctrl_q;
  logic [7:0] ctrl2_q;
  logic [15:0] dpt_q;
  logic [7:0] ast_q;
  logic [7:0] ndt_q;
  logic [7:0] udma_q;
  logic feat_q;
  logic mode_q;
  logic irq_prev_q;
  logic flush_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_d;
  logic [7:0] idx;
  logic wb_req, wr_en, wr_b0, wr_b1;
  logic seq_busy, udma_busy, idle;
  logic seq_start, udma_start, fast_path;
  logic [2:0] setup_n;
  logic [4:0] act_n, rec_n;
  // one strobe period in system clocks, for the width checks at the end
  localparam int PCI_CYC = idt_pkg::PCI_T_CYC;

  // bus decode; writes land on the edge that also sees ack high
  assign idx = wb_adr_i[9:2];
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign wr_b0 = wr_en && wb_sel_i[0];
  assign wr_b1 = wr_en && wb_sel_i[1];

  // read mux; unmapped indices read as zero and ignore writes
  // the part field is a constant, so it costs no flop of its own
  always_comb begin
    rd_d = 32'h0000_0000;
    case (idx)
      idt_pkg::IDX_INT_LINE: rd_d[7:0] = int_line_q;
      idt_pkg::IDX_CTRL: rd_d[7:0] = {PART_ID, 2'h0, ctrl_q};
      idt_pkg::IDX_CTRL2: rd_d[7:0] = ctrl2_q;
      idt_pkg::IDX_DPT: rd_d[15:0] = dpt_q;
      idt_pkg::IDX_AST: rd_d[7:0] = ast_q;
      idt_pkg::IDX_NDT: rd_d[7:0] = ndt_q;
      idt_pkg::IDX_UDMA: rd_d[7:0] = {udma_q[7:6], mode_q, udma_q[4:0]};
      idt_pkg::IDX_STAT: begin
        rd_d[idt_pkg::STAT_BUSY_BIT] = !idle;
        rd_d[idt_pkg::STAT_UDMA_BIT] = mode_q;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // single-wait-state answer, dropped the cycle after it is given
  // answering a cycle late lets read data come straight from a flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_req;
      if (wb_req) dat_q <= rd_d;
    end
  end

  // interrupt line register, guarded by write protect
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) int_line_q <= idt_pkg::RST_INT_LINE;
    else if (wr_b0 && idx == idt_pkg::IDX_INT_LINE && !ctrl2_q[idt_pkg::CTRL2_WP_BIT]) begin
      int_line_q <= wb_dat_i[7:0];
    end
  end

  // control registers; read-only bits are masked off on write
  // bit 7 of the second control keeps whatever software writes, since
  // the hardware gives it no meaning; it is expected to stay at 1
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= idt_pkg::RST_CTRL;
      ctrl2_q <= idt_pkg::RST_CTRL2;
    end else begin
      if (wr_b0 && idx == idt_pkg::IDX_CTRL) ctrl_q <= wb_dat_i[1:0];
      if (wr_b0 && idx == idt_pkg::IDX_CTRL2) begin
        ctrl2_q <= wb_dat_i[7:0] & idt_pkg::MASK_CTRL2;
      end
    end
  end

  // timing registers; the 16-bit one honours both low byte lanes
  // a new value only shapes accesses that start after the write lands
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dpt_q <= idt_pkg::RST_DPT;
      ast_q <= idt_pkg::RST_AST;
      ndt_q <= idt_pkg::RST_NDT;
      udma_q <= idt_pkg::RST_UDMA;
    end else begin
      if (wr_b0 && idx == idt_pkg::IDX_DPT) dpt_q[7:0] <= wb_dat_i[7:0];
      if (wr_b1 && idx == idt_pkg::IDX_DPT) dpt_q[15:8] <= wb_dat_i[15:8];
      if (wr_b0 && idx == idt_pkg::IDX_AST) ast_q <= wb_dat_i[7:0] & idt_pkg::MASK_AST;
      if (wr_b0 && idx == idt_pkg::IDX_NDT) ndt_q <= wb_dat_i[7:0];
      // cable type in bit 4 is only recorded here for software
      if (wr_b0 && idx == idt_pkg::IDX_UDMA) udma_q <= wb_dat_i[7:0] & idt_pkg::MASK_UDMA;
    end
  end

  // kept apart from mode_q so that handing control back to the drive picks up
  // whatever the drive last reported while the register was in charge
  // set-features notice for the slave; a set beats a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) feat_q <= 1'b0;
    else if (feat_udma_set) feat_q <= 1'b1;
    else if (feat_udma_clr) feat_q <= 1'b0;
  end

  // slave transfer mode: register or set-features decides per method bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) mode_q <= 1'b0;
    else if (udma_q[idt_pkg::UDMA_METHOD_BIT]) mode_q <= udma_q[idt_pkg::UDMA_EN_BIT];
    else mode_q <= feat_q;
  end

  // read-DMA flush request on each rising interrupt while enabled
  // edge-detected so that an interrupt held high asks for one flush only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_prev_q <= 1'b0;
      flush_q <= 1'b0;
    end else begin
      irq_prev_q <= dma_irq;
      flush_q <= dma_irq && !irq_prev_q && ctrl2_q[idt_pkg::CTRL2_FLUSH_BIT] &&
                 ctrl_q[idt_pkg::CTRL_EN_BIT];
    end
  end

  // per-drive setup and data port widths, one non-data pair shared by both drives; fields are stored minus one
  // the sequencer latches these at start, so they may change freely afterwards
  always_comb begin
    setup_n = acc_slave ? {1'b0, ast_q[5:4]} + 3'h1 : {1'b0, ast_q[7:6]} + 3'h1;
    if (acc_nondata) begin
      act_n = {1'b0, ndt_q[7:4]} + 5'h01;
      rec_n = {1'b0, ndt_q[3:0]} + 5'h01;
    end else if (acc_slave) begin
      act_n = {1'b0, dpt_q[7:4]} + 5'h01;
      rec_n = {1'b0, dpt_q[3:0]} + 5'h01;
    end else begin
      act_n = {1'b0, dpt_q[15:12]} + 5'h01;
      rec_n = {1'b0, dpt_q[11:8]} + 5'h01;
    end
  end

  // requests are dropped while the channel is off or an access runs
  // a dropped request leaves no trace; the requester must wait for acc_done, or for the fast-DMA strobe to fall on the fast path
  assign idle = !seq_busy && !udma_busy;
  assign fast_path = acc_slave && !acc_nondata && acc_write && mode_q;
  assign seq_start = acc_req && ctrl_q[idt_pkg::CTRL_EN_BIT] && idle && !fast_path;
  assign udma_start = acc_req && ctrl_q[idt_pkg::CTRL_EN_BIT] && idle && fast_path;

  idt_strobe_seq u_seq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(seq_start),
    .write(acc_write),
    .setup_n(setup_n),
    .act_n(act_n),
    .rec_n(rec_n),
    .rd_n_q(primary_read_strobe_n),
    .wr_n_q(primary_write_strobe_n),
    .busy_q(seq_busy),
    .done_q(acc_done)
  );

  idt_udma_pulse u_udma (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(udma_start),
    .setting(udma_q[3:0]),
    .pulse_q(udma_busy)
  );

  assign udma_write_strobe = udma_busy;
  assign addr_valid = seq_busy;
  assign chan_enable = ctrl_q[idt_pkg::CTRL_EN_BIT];
  assign flush_read_dma = flush_q;
  assign irq_route = int_line_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  a_off_no_access: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!ctrl_q[idt_pkg::CTRL_EN_BIT] && idle) |=> idle)
    else $error("access started while channel disabled");
  a_wp_blocks_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_b0 && idx == idt_pkg::IDX_INT_LINE && ctrl2_q[idt_pkg::CTRL2_WP_BIT]) |=>
      $stable(int_line_q))
    else $error("protected interrupt line was written");
  a_wp_open_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_b0 && idx == idt_pkg::IDX_INT_LINE && !ctrl2_q[idt_pkg::CTRL2_WP_BIT]) |=>
      (int_line_q == $past(wb_dat_i[7:0])))
    else $error("open interrupt line write lost");
  a_flush_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($rose(dma_irq) && ctrl2_q[idt_pkg::CTRL2_FLUSH_BIT] && chan_enable) |=> flush_read_dma)
    else $error("no flush after interrupt");
  a_reg_mode_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (udma_q[idt_pkg::UDMA_METHOD_BIT] && !udma_q[idt_pkg::UDMA_EN_BIT]) [*2] |-> !mode_q)
    else $error("fast dma active though disabled by register");
  a_feat_mode_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!udma_q[idt_pkg::UDMA_METHOD_BIT] && feat_udma_set) ##1
      !udma_q[idt_pkg::UDMA_METHOD_BIT] |=> mode_q)
    else $error("set-features did not enable fast dma");
  a_mode_readback: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wb_req && !wb_we_i && idx == idt_pkg::IDX_UDMA) |=>
      (wb_dat_o[idt_pkg::UDMA_MODE_BIT] == $past(mode_q)))
    else $error("mode bit readback mismatch");
  // the width checks read the sequencer's latched counts one cycle after start, so a
  // wrong field, drive or unit shows up there before any strobe has moved
  a_master_width: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (seq_start && !acc_slave && !acc_nondata) |=>
      (u_seq.act_c_q == 8'(({4'h0, $past(dpt_q[15:12])} + 8'h01) * PCI_CYC)) &&
      (u_seq.rec_c_q == 8'(({4'h0, $past(dpt_q[11:8])} + 8'h01) * PCI_CYC)))
    else $error("master data port widths not taken from upper fields");
  a_slave_width: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (seq_start && acc_slave && !acc_nondata) |=>
      (u_seq.act_c_q == 8'(({4'h0, $past(dpt_q[7:4])} + 8'h01) * PCI_CYC)) &&
      (u_seq.rec_c_q == 8'(({4'h0, $past(dpt_q[3:0])} + 8'h01) * PCI_CYC)))
    else $error("slave data port widths wrong");
  a_nondata_width: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (seq_start && acc_nondata) |=>
      (u_seq.act_c_q == 8'(({4'h0, $past(ndt_q[7:4])} + 8'h01) * PCI_CYC)) &&
      (u_seq.rec_c_q == 8'(({4'h0, $past(ndt_q[3:0])} + 8'h01) * PCI_CYC)))
    else $error("non-data port widths wrong");
  a_setup_code: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seq_start |=> (u_seq.set_c_q ==
      8'(({6'h00, $past(acc_slave ? ast_q[5:4] : ast_q[7:6])} + 8'h01) * PCI_CYC)))
    else $error("address setup count wrong");
  a_fast_no_pio: assert property (@(posedge ref_clk) disable iff (!rst_n)
    udma_start |=> (udma_write_strobe && !addr_valid && primary_write_strobe_n))
    else $error("fast dma write used the programmed strobes");
  a_flush_single: assert property (@(posedge ref_clk) disable iff (!rst_n)
    flush_read_dma |=> !flush_read_dma)
    else $error("flush request longer than one cycle");
  a_reg_mode_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (udma_q[idt_pkg::UDMA_METHOD_BIT] && udma_q[idt_pkg::UDMA_EN_BIT]) [*2] |-> mode_q)
    else $error("fast dma off though enabled by register");
  a_strobe_after_setup: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seq_start |=> (primary_read_strobe_n && primary_write_strobe_n && addr_valid))
    else $error("strobe asserted without address setup");
endmodule : idt_chan_ctrl

/* idt_pkg.sv */
/*
  Shared constants for the primary channel timing controller: register
  indices, field positions, reset values, write masks and timing figures.
  Assumes a 200 MHz system clock and word-wide register slots on the bus.
*/
package idt_pkg;
  // clock and timing figures, in their own units
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int PCI_T_NS = 30;
  localparam int PCI_T_CYC = PCI_T_NS / CLK_PERIOD_NS;
  localparam int UDMA_UNIT_PS = 7500;
  localparam int UDMA_FAST_UNIT_PS = 10000;
  localparam int UDMA_ADD = 2;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_INT_LINE = 8'h3C;
  localparam logic [7:0] IDX_CTRL = 8'h40;
  localparam logic [7:0] IDX_CTRL2 = 8'h45;
  localparam logic [7:0] IDX_DPT = 8'h4A;
  localparam logic [7:0] IDX_AST = 8'h4C;
  localparam logic [7:0] IDX_NDT = 8'h4F;
  localparam logic [7:0] IDX_UDMA = 8'h52;
  localparam logic [7:0] IDX_STAT = 8'h60;

  // reset values
  localparam logic [7:0] RST_INT_LINE = 8'h00;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [7:0] RST_CTRL2 = 8'h82;
  localparam logic [15:0] RST_DPT = 16'hA8A8;
  localparam logic [7:0] RST_AST = 8'hF0;
  localparam logic [7:0] RST_NDT = 8'hB6;
  localparam logic [7:0] RST_UDMA = 8'h07;

  // writable bits of the mixed registers
  localparam logic [7:0] MASK_CTRL2 = 8'hD2;
  localparam logic [7:0] MASK_AST = 8'hF0;
  localparam logic [7:0] MASK_UDMA = 8'hDF;

  // field positions
  localparam int CTRL_EN_BIT = 1;
  localparam int CTRL_ID_LSB = 4;
  localparam int CTRL2_FLUSH_BIT = 1;
  localparam int CTRL2_WP_BIT = 4;
  localparam int UDMA_METHOD_BIT = 7;
  localparam int UDMA_EN_BIT = 6;
  localparam int UDMA_MODE_BIT = 5;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_UDMA_BIT = 1;
  localparam logic [3:0] UDMA_FAST_CODE = 4'h1;
endpackage : idt_pkg

/* idt_strobe_seq.sv */
/*
  Strobe sequencer for one task-file access: address setup, then the
  active read or write strobe, then recovery, each a whole number of
  30 ns periods. Assumes start is only raised while busy is low.
*/
`timescale 1ns/100ps
module idt_strobe_seq #(
  parameter int T_CYC = idt_pkg::PCI_T_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic write,
  input wire logic [2:0] setup_n,
  input wire logic [4:0] act_n,
  input wire logic [4:0] rec_n,
  output logic rd_n_q,
  output logic wr_n_q,
  output logic busy_q,
  output logic done_q
);
  typedef enum logic [1:0] {SQ_IDLE, SQ_SETUP, SQ_ACTIVE, SQ_RECOV} idt_seq_e;

  idt_seq_e state_q, state_d;
  logic [7:0] cnt_q;
  logic [7:0] act_c_q, rec_c_q, set_c_q;
  logic [7:0] len_q;
  logic wr_q;

  // counts are held in system clocks, 16 periods at most must fit 8 bits
  if (T_CYC < 1 || T_CYC * 16 > 255) begin : g_bad_t_cyc
    $error("T_CYC out of range");
  end

  // phase walk; each phase ends when its down-counter reaches zero
  always_comb begin
    state_d = state_q;
    case (state_q)
      SQ_IDLE: if (start) state_d = SQ_SETUP;
      SQ_SETUP: if (cnt_q == 8'h00) state_d = SQ_ACTIVE;
      SQ_ACTIVE: if (cnt_q == 8'h00) state_d = SQ_RECOV;
      SQ_RECOV: if (cnt_q == 8'h00) state_d = SQ_IDLE;
      default: state_d = SQ_IDLE;
    endcase
  end

  // widths latched at start so a register write mid-access cannot stretch it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      set_c_q <= 8'h00;
      act_c_q <= 8'h00;
      rec_c_q <= 8'h00;
      wr_q <= 1'b0;
    end else if (state_q == SQ_IDLE && start) begin
      set_c_q <= 8'(setup_n * T_CYC);
      act_c_q <= 8'(act_n * T_CYC);
      rec_c_q <= 8'(rec_n * T_CYC);
      wr_q <= write;
    end
  end

  // state and phase counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SQ_IDLE;
      cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (state_q == SQ_IDLE && start) begin
        cnt_q <= 8'(setup_n * T_CYC) - 8'h01;
      end else if (state_q == SQ_SETUP && cnt_q == 8'h00) begin
        cnt_q <= act_c_q - 8'h01;
      end else if (state_q == SQ_ACTIVE && cnt_q == 8'h00) begin
        cnt_q <= rec_c_q - 8'h01;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  // strobes follow the next state so they line up with state_q
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      rd_n_q <= !(state_d == SQ_ACTIVE && !wr_q);
      wr_n_q <= !(state_d == SQ_ACTIVE && wr_q);
      busy_q <= (state_d != SQ_IDLE);
      done_q <= (state_q == SQ_RECOV && cnt_q == 8'h00);
    end
  end

  // helper: cycles spent in the current phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) len_q <= 8'h00;
    else len_q <= (state_d != state_q) ? 8'h00 : len_q + 8'h01;
  end

  a_setup_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SQ_SETUP && state_d == SQ_ACTIVE) |-> (len_q == set_c_q - 8'h01))
    else $error("address setup phase has wrong length");
  a_active_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SQ_ACTIVE && state_d == SQ_RECOV) |-> (len_q == act_c_q - 8'h01))
    else $error("active strobe has wrong length");
  a_recov_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SQ_RECOV && state_d == SQ_IDLE) |-> (len_q == rec_c_q - 8'h01))
    else $error("recovery phase has wrong length");
endmodule : idt_strobe_seq

/* idt_udma_pulse.sv */
/*
  Fast-DMA write strobe pulse for the slave drive. Width is the 4-bit
  setting plus two, in 7.5 ns units, or 10 ns units for setting 1,
  rounded up to whole system clocks. Assumes start only while idle.
*/
`timescale 1ns/100ps
module idt_udma_pulse (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [3:0] setting,
  output logic pulse_q
);
  logic [7:0] cnt_q;
  logic [7:0] exp_q;
  logic [7:0] len_q;
  logic [7:0] cyc;

  // least time, so round up to whole clocks
  always_comb begin
    int ps;
    ps = (int'(setting) + idt_pkg::UDMA_ADD) * ((setting == idt_pkg::UDMA_FAST_CODE) ?
         idt_pkg::UDMA_FAST_UNIT_PS : idt_pkg::UDMA_UNIT_PS);
    cyc = 8'((ps + idt_pkg::CLK_PERIOD_PS - 1) / idt_pkg::CLK_PERIOD_PS);
  end

  // pulse generator
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_q <= 1'b0;
      cnt_q <= 8'h00;
      exp_q <= 8'h00;
    end else if (start && !pulse_q) begin
      pulse_q <= 1'b1;
      cnt_q <= cyc - 8'h01;
      exp_q <= cyc;
    end else if (pulse_q) begin
      if (cnt_q == 8'h00) pulse_q <= 1'b0;
      else cnt_q <= cnt_q - 8'h01;
    end
  end

  // helper: high cycles of the current pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) len_q <= 8'h00;
    else if (start && !pulse_q) len_q <= 8'h00;
    else if (pulse_q) len_q <= len_q + 8'h01;
  end

  a_udma_width: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(pulse_q) |-> (len_q == exp_q))
    else $error("fast dma write strobe has wrong width");
endmodule : idt_udma_pulse

/* idt_drive_model.sv */
/*
  Behavioural model of the drives on the cable: measures address setup,
  strobe active and recovery widths of each access and the fast-DMA strobe.
  Assumes the controller's outputs are registered on ref_clk.
*/
`timescale 1ns/100ps
module idt_drive_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic addr_valid,
  input wire logic fast_strobe,
  output logic [7:0] setup_cnt,
  output logic [7:0] act_cnt,
  output logic [7:0] rec_cnt,
  output logic [7:0] fast_cnt,
  output logic wrote
);
  logic av_q, low_seen_q, fs_q;
  logic strobe_low;

  assign strobe_low = ~(read_strobe_n & write_strobe_n);

  // phase widths as a drive samples them; restarts when the address goes valid
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      av_q <= 1'b0;
      low_seen_q <= 1'b0;
      setup_cnt <= 8'h00;
      act_cnt <= 8'h00;
      rec_cnt <= 8'h00;
      wrote <= 1'b0;
    end else begin
      av_q <= addr_valid;
      if (addr_valid && !av_q) begin
        setup_cnt <= 8'h01;
        act_cnt <= 8'h00;
        rec_cnt <= 8'h00;
        low_seen_q <= 1'b0;
        wrote <= 1'b0;
      end else if (addr_valid && strobe_low) begin
        act_cnt <= act_cnt + 8'h01;
        low_seen_q <= 1'b1;
        wrote <= wrote | ~write_strobe_n;
      end else if (addr_valid && low_seen_q) begin
        rec_cnt <= rec_cnt + 8'h01;
      end else if (addr_valid) begin
        setup_cnt <= setup_cnt + 8'h01;
      end
    end
  end

  // fast-DMA strobe width in system clocks
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fs_q <= 1'b0;
      fast_cnt <= 8'h00;
    end else begin
      fs_q <= fast_strobe;
      if (fast_strobe && !fs_q) fast_cnt <= 8'h01;
      else if (fast_strobe) fast_cnt <= fast_cnt + 8'h01;
    end
  end
endmodule : idt_drive_model

/* idt_chan_ctrl_bench.sv */
/*
  Self-checking bench for the channel timing controller: registers over
  classic Wishbone, strobe timing measured by the drive model, flush and
  fast-DMA mode. Assumes one 200 MHz clock and the design's own assertions.
*/
`timescale 1ns/100ps
module idt_chan_ctrl_bench;
  localparam logic [3:0] PID = 4'h5; // arbitrary identification value
  localparam int T = idt_pkg::PCI_T_CYC;
  logic ref_clk, rst_n, cyc, stb, we, acc_req, acc_slave, acc_nondata, acc_write;
  logic feat_set, feat_clr, dma_irq, ack, rd_n, wr_n, fast, av, done, en, flush, wrote;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_i, dat_o, rd;
  logic [7:0] route, s_cnt, a_cnt, r_cnt, f_cnt;
  int mismatches, num_checks;

  idt_chan_ctrl #(.ADR_W(10), .PART_ID(PID)) idt_chan_ctrl_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack), .acc_req(acc_req),
    .acc_slave(acc_slave), .acc_nondata(acc_nondata), .acc_write(acc_write),
    .feat_udma_set(feat_set), .feat_udma_clr(feat_clr), .dma_irq(dma_irq),
    .primary_read_strobe_n(rd_n), .primary_write_strobe_n(wr_n), .udma_write_strobe(fast),
    .addr_valid(av), .acc_done(done), .chan_enable(en), .flush_read_dma(flush),
    .irq_route(route));

  idt_drive_model idt_drive_model_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .addr_valid(av), .fast_strobe(fast),
    .setup_cnt(s_cnt), .act_cnt(a_cnt), .rec_cnt(r_cnt), .fast_cnt(f_cnt), .wrote(wrote));

  // free-running system clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // one classic cycle; request held until ack is sampled, then released
  task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat_i <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk({31'h0, ack}, 32'h1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge ref_clk);
  endtask : wb

  task automatic rchk(input logic [7:0] idx, input logic [15:0] exp);
    wb(1'b0, idx, 16'h0000);
    chk(rd, {16'h0000, exp});
  endtask : rchk

  // one access; setup, active and recovery widths judged in system clocks
  task automatic acc(input logic s, nd, w, input int code, act, rec);
    int n;
    acc_req <= 1'b1;
    acc_slave <= s;
    acc_nondata <= nd;
    acc_write <= w;
    @(posedge ref_clk);
    acc_req <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (done !== 1'b1 && n < 400);
    chk({24'h0, s_cnt}, 32'((code + 1) * T));
    chk({24'h0, a_cnt}, 32'((act + 1) * T));
    chk({24'h0, r_cnt}, 32'((rec + 1) * T));
    chk({31'h0, wrote}, {31'h0, w});
    @(posedge ref_clk);
  endtask : acc

  task automatic fdma(input int v);
    int n, unit;
    unit = (v == 1) ? idt_pkg::UDMA_FAST_UNIT_PS : idt_pkg::UDMA_UNIT_PS;
    wb(1'b1, 8'h52, 16'(8'hD0 | v));
    acc_req <= 1'b1;
    acc_slave <= 1'b1;
    acc_nondata <= 1'b0;
    acc_write <= 1'b1;
    @(posedge ref_clk);
    acc_req <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (fast !== 1'b1 && n < 10);
    do begin
      @(posedge ref_clk);
      n++;
    end while (fast === 1'b1 && n < 60);
    chk({24'h0, f_cnt}, 32'(((v + 2) * unit + idt_pkg::CLK_PERIOD_PS - 1) / 5000));
  endtask : fdma

  task automatic pulse_irq(output int cnt);
    dma_irq <= 1'b1;
    cnt = 0;
    repeat (4) begin
      @(posedge ref_clk);
      if (flush === 1'b1) cnt++;
    end
    dma_irq <= 1'b0;
    @(posedge ref_clk);
  endtask : pulse_irq

  task automatic t_reset();
    rchk(8'h3C, 16'h0000);
    rchk(8'h40, {8'h00, PID, 4'h0});
    rchk(8'h45, 16'h0082);
    rchk(8'h4A, 16'hA8A8);
    rchk(8'h4C, 16'h00F0);
    rchk(8'h4F, 16'h00B6);
    rchk(8'h52, 16'h0007);
    rchk(8'h41, 16'h0000);
    rchk(8'h60, 16'h0000);
    chk({31'h0, en}, 32'h0);
  endtask : t_reset

  // requests while disabled must leave the cable idle
  task automatic t_enable();
    int seen;
    wb(1'b1, 8'h40, 16'h00F1);
    rchk(8'h40, {8'h00, PID, 4'h1});
    acc_req <= 1'b1;
    @(posedge ref_clk);
    acc_req <= 1'b0;
    seen = 0;
    repeat (12) begin
      @(posedge ref_clk);
      if (av !== 1'b0) seen++;
    end
    chk(seen, 0);
    wb(1'b1, 8'h40, 16'h00F2);
    chk({31'h0, en}, 32'h1);
  endtask : t_enable

  task automatic t_irq_line();
    wb(1'b1, 8'h3C, 16'h005A);
    chk({24'h0, route}, 32'h5A);
    wb(1'b1, 8'h45, 16'h0092); // bit 7 stays one
    rchk(8'h45, 16'h0092);
    wb(1'b1, 8'h3C, 16'h0033);
    rchk(8'h3C, 16'h005A);
    wb(1'b1, 8'h45, 16'h0082);
    wb(1'b1, 8'h3C, 16'h0033);
    rchk(8'h3C, 16'h0033);
  endtask : t_irq_line

  task automatic t_flush();
    int c;
    pulse_irq(c);
    chk(c, 1);
    wb(1'b1, 8'h45, 16'h0080);
    pulse_irq(c);
    chk(c, 0);
    wb(1'b1, 8'h45, 16'h0082);
  endtask : t_flush

  task automatic t_strobes();
    acc(1'b0, 1'b0, 1'b0, 3, 10, 8);
    wb(1'b1, 8'h4A, 16'h3152);
    wb(1'b1, 8'h4C, 16'h0040);
    acc(1'b0, 1'b0, 1'b1, 1, 3, 1);
    acc(1'b1, 1'b0, 1'b0, 0, 5, 2);
    wb(1'b1, 8'h4F, 16'h0020);
    acc(1'b0, 1'b1, 1'b1, 1, 2, 0);
    acc(1'b1, 1'b1, 1'b0, 0, 2, 0);
  endtask : t_strobes

  // cable type written as 80-pin throughout
  task automatic t_fast();
    wb(1'b1, 8'h52, 16'h00D7);
    rchk(8'h52, 16'h00F7);
    rchk(8'h60, 16'h0002);
    fdma(7);
    fdma(1);
    fdma(0);
    fdma(15);
    wb(1'b1, 8'h52, 16'h0097);
    rchk(8'h52, 16'h0097);
    rchk(8'h60, 16'h0000);
    acc(1'b1, 1'b0, 1'b1, 0, 5, 2);
    wb(1'b1, 8'h52, 16'h0017);
    feat_set <= 1'b1;
    @(posedge ref_clk);
    feat_set <= 1'b0;
    @(posedge ref_clk);
    rchk(8'h52, 16'h0037);
    feat_clr <= 1'b1;
    @(posedge ref_clk);
    feat_clr <= 1'b0;
    @(posedge ref_clk);
    rchk(8'h52, 16'h0017);
  endtask : t_fast

  // main sequence
  initial begin
    {cyc, stb, we, acc_req, acc_slave, acc_nondata, acc_write} = '0;
    {feat_set, feat_clr, dma_irq} = '0;
    adr = '0;
    sel = 4'h3;
    dat_i = '0;
    rd = '0;
    mismatches = 0;
    num_checks = 0;
    rst_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_enable();
    t_irq_line();
    t_flush();
    t_strobes();
    t_fast();
    stop_test();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    stop_test();
  end
endmodule : idt_chan_ctrl_bench
